// [include/eppctl_pkg.sv]
// package for the parallel host port: offsets, control bit fields, timing
// assumes a 10 MHz device clock and a 3-bit ISA port offset
package eppctl_pkg;
    // port offsets from the base address
    localparam logic [2:0] OFS_DATA    = 3'h0;
    localparam logic [2:0] OFS_STATUS  = 3'h1;
    localparam logic [2:0] OFS_CONTROL = 3'h2;
    localparam logic [2:0] OFS_ADDR    = 3'h3;
    localparam logic [2:0] OFS_DWIN0   = 3'h4;
    // control register fields
    localparam int CTL_STROBE = 0;
    localparam int CTL_LFEED  = 1;
    localparam int CTL_INIT   = 2;
    localparam int CTL_SELIN  = 3;
    localparam int CTL_IRQEN  = 4;
    localparam int CTL_DIR    = 5;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // status register fields
    localparam int STS_TIMEOUT_FLAG = 0;
    localparam int STS_ACK   = 6;
    localparam int STS_BUSY  = 7;
    // port modes
    localparam logic [1:0] MODE_PRINTER = 2'h0;
    localparam logic [1:0] MODE_BIDIR   = 2'h1;
    localparam logic [1:0] MODE_EPP     = 2'h2;
    localparam logic [1:0] MODE_ECP     = 2'h3;
    // watchdog timing
    localparam int CLK_HZ     = 10_000_000;
    localparam int TIMEOUT_FLAG_US   = 10;
    localparam int TIMEOUT_FLAG_CYC  = TIMEOUT_FLAG_US * (CLK_HZ / 1_000_000);
    localparam logic [7:0] TIMEOUT_FLAG_CNT = 8'(TIMEOUT_FLAG_CYC);
    // cycle sequencer states
    typedef enum logic [2:0] {
        EPC_IDLE  = 3'b000,
        EPC_ARM   = 3'b001,
        EPC_STRB  = 3'b010,
        EPC_DONE  = 3'b011,
        EPC_ABORT = 3'b100
    } eppctl_state_t;
endpackage : eppctl_pkg

// [src/eppctl_port.sv]
// parallel host port: control port outputs, EPP address/data cycles, watchdog
// assumes host strobes and peripheral pins are asynchronous to ref_clk
// and that host address, select and data settle before the strobe edge
`timescale 1ns/100ps
`default_nettype none
module eppctl_port
    import eppctl_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // configuration
    input  wire logic [1:0] portMode,
    input  wire logic       epp17Mode,
    // host ISA side
    input  wire logic [2:0] hostAddr,
    input  wire logic       hostCs,
    input  wire logic       hostRd_n,
    input  wire logic       hostWr_n,
    input  wire logic [7:0] hostDataLinesIn,
    output logic      [7:0] hostDataLinesOut,
    output logic            hostDataLinesOe,
    output logic            hostReady,
    output logic            irqReq,
    // peripheral side
    input  wire logic [7:0] portDataLinesIn,
    output logic      [7:0] portDataLinesOut,
    output logic            portDataLinesOe,
    output logic            busDirectionOutput,
    output logic            strobePin_n,
    output logic            linefeedPin_n,
    output logic            initPin_n,
    output logic            selectInPin_n,
    output logic            writePin_n,
    output logic            addressStrobe_n,
    output logic            dataStrobe_n,
    input  wire logic       ackInput,
    input  wire logic       busyInput,
    input  wire logic       wait_n
);
    // two-stage synchronisers for asynchronous inputs
    // idle levels chosen so that no false edge follows reset
    logic [1:0] rdSync_ff, wrSync_ff, ackSync_ff, waitSync_ff, busySync_ff;
    logic [7:0] pdS1_ff, pdS2_ff;
    logic       ackLast_ff;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdSync_ff   <= 2'h3;
            wrSync_ff   <= 2'h3;
            ackSync_ff  <= 2'h0;
            waitSync_ff <= 2'h3;
            busySync_ff <= 2'h0;
            pdS1_ff     <= BYTE_ZERO;
            pdS2_ff     <= BYTE_ZERO;
            ackLast_ff  <= 1'b0;
        end else begin
            rdSync_ff   <= {rdSync_ff[0], hostRd_n};
            wrSync_ff   <= {wrSync_ff[0], hostWr_n};
            ackSync_ff  <= {ackSync_ff[0], ackInput};
            waitSync_ff <= {waitSync_ff[0], wait_n};
            busySync_ff <= {busySync_ff[0], busyInput};
            pdS1_ff     <= portDataLinesIn;
            pdS2_ff     <= pdS1_ff;
            ackLast_ff  <= ackSync_ff[1];
        end
    end

    // host strobes only count while the port is selected; address, select
    // and mode are taken as steady for the whole of a host cycle
    logic rdAct, wrAct, waitAct;
    assign rdAct   = ~rdSync_ff[1] & hostCs;
    assign wrAct   = ~wrSync_ff[1] & hostCs;
    assign waitAct = ~waitSync_ff[1];

    // decode an EPP port offset (address or one of four data windows)
    function automatic logic isEppOfs(input logic [2:0] a);
        isEppOfs = (a == OFS_ADDR) || (a >= OFS_DWIN0);
    endfunction : isEppOfs

    // register and sequencer state
    logic [5:0]    ctl_ff, nxt_ctl;
    logic [7:0]    dataReg_ff, nxt_dataReg;
    logic [7:0]    eppLatch_ff, nxt_eppLatch;
    logic          timeout_flag_ff, nxt_timeout_flag;
    logic          irq_ff, nxt_irq;
    logic          wrPrev_ff, nxt_wrPrev;
    eppctl_state_t st_ff, nxt_st;
    logic          cycWrite_ff, nxt_cycWrite;
    logic          cycAddr_ff, nxt_cycAddr;
    logic [7:0]    wdog_ff, nxt_wdog;
    logic          eppMode, eppStart, dirIn;

    assign eppMode  = (portMode == MODE_EPP);
    assign eppStart = eppMode && isEppOfs(hostAddr) && (rdAct || wrAct);
    // a cycle starts only from an EPP window while EPP mode is selected
    // direction bit is meaningless in printer mode
    assign dirIn    = (portMode != MODE_PRINTER) && ctl_ff[CTL_DIR];

    // next-state logic for registers, irq and EPP sequencer
    always_comb begin
        nxt_ctl      = ctl_ff;
        nxt_dataReg  = dataReg_ff;
        nxt_eppLatch = eppLatch_ff;
        nxt_timeout_flag    = timeout_flag_ff;
        nxt_irq      = irq_ff;
        nxt_wrPrev   = wrAct;
        nxt_st       = st_ff;
        nxt_cycWrite = cycWrite_ff;
        nxt_cycAddr  = cycAddr_ff;
        nxt_wdog     = wdog_ff;

        // register writes on the trailing edge of the write strobe
        if (wrPrev_ff && !wrAct && st_ff == EPC_IDLE) begin
            if (hostAddr == OFS_DATA) begin
                nxt_dataReg = hostDataLinesIn;
            end else if (hostAddr == OFS_CONTROL) begin
                nxt_ctl = hostDataLinesIn[5:0];
            end else if (hostAddr == OFS_STATUS && hostDataLinesIn[STS_TIMEOUT_FLAG]) begin
                nxt_timeout_flag = 1'b0;
            end
        end

        // interrupt request on rising ack, only while enabled
        if (!ctl_ff[CTL_IRQEN]) begin
            nxt_irq = 1'b0;
        end else if (ackSync_ff[1] && !ackLast_ff) begin
            nxt_irq = 1'b1;
        end else if (rdAct && hostAddr == OFS_STATUS) begin
            nxt_irq = 1'b0;
        end

        // watchdog runs on the device clock during a cycle
        if (st_ff == EPC_IDLE || st_ff == EPC_ABORT) begin
            nxt_wdog = 8'h00;
        end else if (wdog_ff != TIMEOUT_FLAG_CNT) begin
            nxt_wdog = wdog_ff + 8'h01;
        end

        // cycle sequencer: idle, arm (1.9 only), strobe, done or abort
        case (st_ff)
            EPC_IDLE: begin
                if (eppStart) begin
                    // write with direction set runs as a read
                    nxt_cycWrite = wrAct && !ctl_ff[CTL_DIR];
                    nxt_cycAddr  = (hostAddr == OFS_ADDR);
                    if (wrAct) begin
                        nxt_eppLatch = hostDataLinesIn;
                    end
                    nxt_st = epp17Mode ? EPC_STRB : EPC_ARM;
                end
            end
            EPC_ARM: begin
                // 1.9: wait until peripheral asserts wait
                if (waitAct) begin
                    nxt_st = EPC_STRB;
                end
            end
            EPC_STRB: begin
                if (cycWrite_ff && wrAct) begin
                    nxt_eppLatch = hostDataLinesIn;
                end
                if (!epp17Mode && !waitAct) begin
                    if (!cycWrite_ff) begin
                        nxt_eppLatch = pdS2_ff;
                    end
                    nxt_st = EPC_DONE;
                end else if (epp17Mode && !(rdAct || wrAct)) begin
                    if (!cycWrite_ff) begin
                        nxt_eppLatch = pdS2_ff;
                    end
                    nxt_st = EPC_IDLE;
                end
            end
            EPC_DONE: begin
                // wait for the host to end its strobe
                if (!(rdAct || wrAct)) begin
                    nxt_st = EPC_IDLE;
                end
            end
            EPC_ABORT: begin
                // hold off until the host lets go of its strobe
                if (!(rdAct || wrAct)) begin
                    nxt_st = EPC_IDLE;
                end
            end
            default: nxt_st = EPC_IDLE;
        endcase

        // watchdog expiry aborts the cycle; set wins over clear
        if ((st_ff == EPC_ARM || st_ff == EPC_STRB) && wdog_ff == TIMEOUT_FLAG_CNT) begin
            nxt_timeout_flag = 1'b1;
            nxt_st    = EPC_ABORT;
        end
    end

    // state registers
    // reset returns every latch and the sequencer to idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff      <= CTL_RESET;
            dataReg_ff  <= BYTE_ZERO;
            eppLatch_ff <= BYTE_ZERO;
            timeout_flag_ff    <= 1'b0;
            irq_ff      <= 1'b0;
            wrPrev_ff   <= 1'b0;
            st_ff       <= EPC_IDLE;
            cycWrite_ff <= 1'b0;
            cycAddr_ff  <= 1'b0;
            wdog_ff     <= 8'h00;
        end else begin
            ctl_ff      <= nxt_ctl;
            dataReg_ff  <= nxt_dataReg;
            eppLatch_ff <= nxt_eppLatch;
            timeout_flag_ff    <= nxt_timeout_flag;
            irq_ff      <= nxt_irq;
            wrPrev_ff   <= nxt_wrPrev;
            st_ff       <= nxt_st;
            cycWrite_ff <= nxt_cycWrite;
            cycAddr_ff  <= nxt_cycAddr;
            wdog_ff     <= nxt_wdog;
        end
    end

    // peripheral-side outputs
    // the arm phase leaves the pins as idle: nothing may move before the
    // peripheral has shown wait asserted
    logic inCyc, strbOn, driveOut;
    assign inCyc  = (st_ff != EPC_IDLE) && (st_ff != EPC_ARM);
    assign strbOn = (st_ff == EPC_STRB);
    // strobe bit forces write direction during a cycle
    assign driveOut = inCyc ? (cycWrite_ff || ctl_ff[CTL_STROBE])
                            : !dirIn;
    assign portDataLinesOe    = driveOut;
    assign busDirectionOutput = !driveOut;
    assign portDataLinesOut   = (inCyc && cycWrite_ff) ? eppLatch_ff : dataReg_ff;
    assign writePin_n         = !(inCyc && (cycWrite_ff || ctl_ff[CTL_STROBE]));
    assign addressStrobe_n    = !(strbOn && cycAddr_ff);
    assign dataStrobe_n       = !(strbOn && !cycAddr_ff);
    // control pins follow the register directly
    assign strobePin_n        = !ctl_ff[CTL_STROBE];
    assign linefeedPin_n      = !ctl_ff[CTL_LFEED];
    assign initPin_n          = ctl_ff[CTL_INIT];
    assign selectInPin_n      = !ctl_ff[CTL_SELIN];
    assign irqReq             = irq_ff;

    // ready low from cycle start until completion (1.7: while wait active)
    // only the address and data windows stretch the host; register
    // accesses always complete at once
    // in 1.7 the first cycle, before the strobe is out, is held as well
    always_comb begin
        if (!eppMode || !isEppOfs(hostAddr) || !(rdAct || wrAct) || st_ff == EPC_ABORT) begin
            hostReady = 1'b1;
        end else if (epp17Mode) begin
            hostReady = !(waitAct && (strbOn || st_ff == EPC_IDLE));
        end else begin
            hostReady = (st_ff == EPC_DONE);
        end
    end

    // host read data multiplexer
    // status bits 1 to 5 read low; EPP windows return the last latched byte
    always_comb begin
        hostDataLinesOut = BYTE_ZERO;
        if (hostAddr == OFS_DATA) begin
            hostDataLinesOut = dirIn ? pdS2_ff : dataReg_ff;
        end else if (hostAddr == OFS_STATUS) begin
            hostDataLinesOut[STS_TIMEOUT_FLAG] = timeout_flag_ff;
            hostDataLinesOut[STS_ACK]   = ackSync_ff[1];
            hostDataLinesOut[STS_BUSY]  = !busySync_ff[1];
        end else if (hostAddr == OFS_CONTROL) begin
            hostDataLinesOut = {2'b00, ctl_ff};
        end else if (eppMode) begin
            hostDataLinesOut = eppLatch_ff;
        end
    end
    // reads of the EPP windows outside EPP mode leave the host bus alone
    assign hostDataLinesOe = rdAct && !(isEppOfs(hostAddr) && !eppMode);
endmodule : eppctl_port
`default_nettype wire

// [tb/eppctl_sva.sv]
// checker: strobe, ready, direction, irq of eppctl_port
// bound to eppctl_port, one ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module eppctl_sva
    import eppctl_pkg::*;
(
    // clock, reset, config
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [1:0] portMode,
    input wire logic       epp17Mode,
    // host side
    input wire logic [2:0] hostAddr,
    input wire logic       hostDataLinesOe,
    input wire logic       hostReady,
    input wire logic       irqReq,
    // peripheral side
    input wire logic       portDataLinesOe,
    input wire logic       busDirectionOutput,
    input wire logic       writePin_n,
    input wire logic       addressStrobe_n,
    input wire logic       dataStrobe_n,
    input wire logic       ackInput,
    input wire logic       wait_n
);
    localparam int LOW_MAX = 110;
    logic [7:0] lowCnt_ff;
    logic [7:0] nxt_lowCnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles the host is held off
    always_comb nxt_lowCnt = hostReady ? 8'h00 : lowCnt_ff + 8'h01;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) lowCnt_ff <= 8'h00;
        else lowCnt_ff <= nxt_lowCnt;
    end
    // strobe phases
    sequence s_wr; !(dataStrobe_n && addressStrobe_n) && !writePin_n; endsequence
    sequence s_rd; !(dataStrobe_n && addressStrobe_n) && writePin_n; endsequence
    sequence s_on19; !(dataStrobe_n && addressStrobe_n) && !epp17Mode; endsequence
    a_one_strobe: assert property (dataStrobe_n || addressStrobe_n)
        else $error("both strobes low");
    a_write_drive: assert property (s_wr |-> portDataLinesOe && !busDirectionOutput)
        else $error("write strobe, bus not driven");
    a_read_float: assert property (s_rd |-> !portDataLinesOe && busDirectionOutput)
        else $error("read strobe, bus driven");
    a_ready_held: assert property (s_on19 |-> !hostReady)
        else $error("ready high under strobe");
    a_wait_first: assert property ($fell(dataStrobe_n && addressStrobe_n) && !epp17Mode
        |-> !wait_n)
        else $error("strobe before wait asserted");
    a_strobe_release: assert property ($rose(dataStrobe_n && addressStrobe_n) && !epp17Mode
        |-> hostReady)
        else $error("strobe ended, ready low");
    a_hold_bound: assert property (lowCnt_ff < LOW_MAX)
        else $error("host held past watchdog");
    a_irq_cause: assert property ($rose(irqReq) |-> $past(ackInput, 1))
        else $error("irq without ack");
    a_printer_out: assert property ((portMode == MODE_PRINTER) [*3]
        |-> portDataLinesOe && !busDirectionOutput)
        else $error("printer mode not output");
    a_epp_only: assert property ((hostAddr >= OFS_ADDR && portMode != MODE_EPP) [*3]
        |-> !hostDataLinesOe)
        else $error("epp port read outside epp");
endmodule : eppctl_sva
bind eppctl_port eppctl_sva i_eppctl_sva (.ref_clk, .rst_n, .portMode, .epp17Mode,
    .hostAddr, .hostDataLinesOe, .hostReady, .irqReq, .portDataLinesOe,
    .busDirectionOutput, .writePin_n, .addressStrobe_n, .dataStrobe_n, .ackInput, .wait_n);
`default_nettype wire

// [tb/eppctl_periph.sv]
// peripheral model: answers strobes with the wait handshake
// assumes resolved port data on busIn, shared ref_clk
`timescale 1ns/100ps
`default_nettype none
module eppctl_periph (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // pins from the port
    input  wire logic       writePin_n,
    input  wire logic       addressStrobe_n,
    input  wire logic       dataStrobe_n,
    input  wire logic [7:0] busIn,
    // answer delay and read byte
    input  wire logic [7:0] dly,
    input  wire logic [7:0] rdByte,
    // pins to the port, observations
    output logic            wait_n,
    output logic      [7:0] busOut,
    output logic      [7:0] seenByte,
    output logic            seenAddr,
    output logic            seenWrite
);
    logic [7:0] cnt;
    logic       busDrv;
    // release wait after dly+1 strobe cycles, rearm when strobe ends
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            wait_n <= 1'b0;
            busDrv <= 1'b0;
            busOut <= 8'h00;
        end else begin
            if (!(addressStrobe_n && dataStrobe_n) && !wait_n) begin
                cnt <= cnt + 8'h01;
                if (writePin_n) begin
                    busDrv <= 1'b1;
                    busOut <= rdByte;
                end else if (!busDrv) begin
                    busOut <= ~busOut; // released bus keeps changing
                end
                if (cnt == dly) begin
                    wait_n <= 1'b1;
                    seenByte <= busIn;
                    seenAddr <= !addressStrobe_n;
                    seenWrite <= !writePin_n;
                end
            end else if (addressStrobe_n && dataStrobe_n) begin
                cnt <= 8'h00;
                wait_n <= 1'b0;
                busDrv <= 1'b0;
                busOut <= ~busOut; // released bus keeps changing
            end
        end
    end
endmodule : eppctl_periph
`default_nettype wire

// [tb/tb_epp_parallel_port_control.sv]
// testbench: eppctl_port against a peripheral model, self-checking
// assumes eppctl_pkg compiled first, 10 MHz ref_clk
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module tb_epp_parallel_port_control;
    import eppctl_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] portMode = MODE_PRINTER;
    logic       epp17Mode = 1'b0;
    logic [2:0] hostAddr = 3'h0;
    logic       hostRd_n = 1'b1;
    logic       hostWr_n = 1'b1;
    logic [7:0] hostDataLinesIn = 8'h00;
    logic       ackInput = 1'b0;
    logic [7:0] dly = 8'h02;
    logic [7:0] rdByte = 8'h00;
    logic [7:0] q, v;
    logic       o;
    wire  [7:0] hOut, pOut, pIn, bOut, sByte;
    wire        hOe, hostReady, irqReq, pOe, bDir, stb_n, lf_n, ini_n, sel_n;
    wire        wr_n, as_n, ds_n, wait_n, sAddr, sWrite;
    int         fails = 0;
    int         num_checks = 0;
    int         toM = 0;
    assign pIn = pOe ? pOut : bOut;
    always #50 ref_clk = ~ref_clk;
    eppctl_port i_eppctl_port (.ref_clk(ref_clk), .rst_n(rst_n), .portMode(portMode),
        .epp17Mode(epp17Mode), .hostAddr(hostAddr), .hostCs(1'b1), .hostRd_n(hostRd_n),
        .hostWr_n(hostWr_n), .hostDataLinesIn(hostDataLinesIn), .hostDataLinesOut(hOut),
        .hostDataLinesOe(hOe), .hostReady(hostReady), .irqReq(irqReq), .portDataLinesIn(pIn),
        .portDataLinesOut(pOut), .portDataLinesOe(pOe), .busDirectionOutput(bDir),
        .strobePin_n(stb_n), .linefeedPin_n(lf_n), .initPin_n(ini_n), .selectInPin_n(sel_n),
        .writePin_n(wr_n), .addressStrobe_n(as_n), .dataStrobe_n(ds_n), .ackInput(ackInput),
        .busyInput(1'b0), .wait_n(wait_n));
    eppctl_periph i_eppctl_periph (.ref_clk(ref_clk), .rst_n(rst_n), .writePin_n(wr_n),
        .addressStrobe_n(as_n), .dataStrobe_n(ds_n), .busIn(pIn), .dly(dly), .rdByte(rdByte),
        .wait_n(wait_n), .busOut(bOut), .seenByte(sByte), .seenAddr(sAddr), .seenWrite(sWrite));
    // one host access, held until ready, data taken into q
    task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d, input int hold);
        int n = 0;
        @(posedge ref_clk);
        hostAddr <= a;
        hostDataLinesIn <= d;
        @(posedge ref_clk);
        hostRd_n <= !rd;
        hostWr_n <= rd;
        repeat (hold) @(posedge ref_clk);
        @(negedge ref_clk);
        while (hostReady !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        q = hOut;
        o = hOe;
        `CHK(n < 300, 1'b1)
        @(posedge ref_clk);
        hostRd_n <= 1'b1;
        hostWr_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
    endtask : acc
    // control write, read back, pins
    task automatic ctl(input logic [7:0] c);
        acc(1'b0, OFS_CONTROL, c, 4);
        acc(1'b1, OFS_CONTROL, 8'h00, 4);
        `CHK(q, {2'b00, c[5:0]})
        `CHK({stb_n, lf_n, ini_n, sel_n}, {~c[0], ~c[1], c[2], ~c[3]})
    endtask : ctl
    // status read against the timeout model
    task automatic stat();
        acc(1'b1, OFS_STATUS, 8'h00, 4);
        `CHK(q[0], toM[0])
    endtask : stat
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // cut a hung run short
    initial begin
        #2_000_000;
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        void'($urandom(1));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK({stb_n, ini_n, wr_n, hostReady}, 4'b1011)
        for (int i = 0; i < 8; i++) begin
            portMode <= (i < 4) ? MODE_PRINTER : MODE_BIDIR;
            v = 8'($urandom);
            ctl(v);
            `CHK({pOe, bDir}, {(i < 4) | ~v[5], (i >= 4) & v[5]})
        end
        portMode <= MODE_EPP;
        ctl(8'h04);
        for (int a = 3; a < 8; a++) begin
            v = 8'($urandom);
            dly <= 8'(2 + $urandom % 15);
            acc(1'b0, 3'(a), v, 4);
            `CHK({sByte, sAddr, sWrite}, {v, a == 3, 1'b1})
            rdByte <= 8'($urandom);
            acc(1'b1, 3'(a), 8'h00, 4);
            `CHK({q, sAddr, sWrite}, {rdByte, a == 3, 1'b0})
            `CHK(o, 1'b1)
        end
        ctl(8'h24);
        acc(1'b0, 3'h4, 8'h5A, 4);
        `CHK(sWrite, 1'b0)
        stat();
        ctl(8'h05);
        acc(1'b1, 3'h4, 8'h00, 4);
        `CHK(sWrite, 1'b1)
        ctl(8'h04);
        dly <= 8'hC8;
        acc(1'b0, 3'h4, 8'hA5, 4);
        toM = 1;
        stat();
        acc(1'b0, OFS_STATUS, 8'h00, 4);
        stat();
        acc(1'b0, OFS_STATUS, 8'h01, 4);
        toM = 0;
        stat();
        epp17Mode <= 1'b1;
        dly <= 8'h03;
        acc(1'b0, OFS_ADDR, 8'h3C, 6);
        `CHK({sByte, sAddr}, {8'h3C, 1'b1})
        acc(1'b0, 3'h4, 8'h11, 150);
        toM = 1;
        stat();
        portMode <= MODE_BIDIR;
        for (int e = 1; e >= 0; e--) begin
            ctl(e ? 8'h10 : 8'h00);
            ackInput <= 1'b1;
            repeat (6) @(posedge ref_clk);
            ackInput <= 1'b0;
            repeat (2) @(negedge ref_clk);
            `CHK(irqReq, 1'(e))
            stat();
            `CHK(irqReq, 1'b0)
        end
        acc(1'b1, 3'h6, 8'h00, 4);
        `CHK({o, q}, 9'h000)
        print_verdict();
    end
endmodule : tb_epp_parallel_port_control
`default_nettype wire
